// file: src/srr_pkg.sv
/*
  Shared constants, state codes and ring arithmetic for the status ring
  and receive-address ring DMA block.
  Assumes a 24-bit byte-addressed shared memory reached one byte at a time.
*/
`default_nettype none

package srr_pkg;

  // ------------------------------------------------------------
  // Widths and slot markers
  // ------------------------------------------------------------
  localparam int AW = 24;
  localparam int SIZE_W = 15;
  localparam int INFO_BYTES = 15;
  localparam logic [7:0] SLOT_FREE = 8'hFF;
  localparam logic [7:0] SLOT_READY = 8'h00;
  localparam logic [7:0] SLOT_CHAIN = 8'hF0;
  localparam int CMD_SHIFT = 4;
  localparam int STS_SHIFT = 4;
  localparam int RXA_SHIFT = 2;
  localparam logic [SIZE_W-1:0] BUF_MAX = 15'h4000;
  localparam logic [3:0] RX_STS_LEN = 4'h2;
  localparam logic [1:0] ADDR_BYTES = 2'h3;

  // ------------------------------------------------------------
  // Sequencer states, Gray along the status path through S_STS_DET
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_STS_CHK = 4'h1,
    S_STS_DET = 4'h3,
    S_STS_NUM = 4'h2,
    S_RXA_CHK = 4'h6,
    S_RXA_ADR = 4'h7,
    S_RXA_MRK = 4'h5,
    S_RXD = 4'h4,
    S_CHD = 4'hC
  } srr_state_t;

  // ------------------------------------------------------------
  // Ring arithmetic
  // ------------------------------------------------------------
  function automatic logic [6:0] ring_mask(input logic [2:0] lg);
    return 7'((8'h01 << lg) - 8'h01);
  endfunction

  function automatic logic [6:0] ring_next(input logic [6:0] p, input logic [2:0] lg);
    return (p + 7'h01) & ring_mask(lg);
  endfunction

  function automatic logic [AW-1:0] ring_span(input logic [2:0] lg, input int sh);
    return (AW'(24'h000001 << lg)) << sh;
  endfunction

  function automatic logic [AW-1:0] ring_addr(input logic [AW-1:0] base,
      input logic [6:0] p, input logic [2:0] lg, input int sh);
    logic [AW-1:0] off;
    off = AW'(p & ring_mask(lg)) << sh;
    return base + off;
  endfunction

endpackage

`default_nettype wire

// file: src/srr_rings.sv
/*
  Receive data FIFO and the ring DMA sequencer that posts status entries
  and fetches receive buffer addresses over a byte-wide shared bus.
  Assumes the host grants the bus by a hold handshake and answers each
  strobe with one MEM_ACK cycle; all inputs are synchronous to CORE_CLK.
*/
`default_nettype none

module srr_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } srr_fifo_t;

  srr_fifo_t f_q, f_d;
  logic push, pop;

  assign in_ready = f_q.cnt != (PW+1)'(D);
  assign out_valid = f_q.cnt != '0;
  assign out_data = f_q.mem[f_q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    f_d = f_q;
    if (push) begin
      f_d.mem[f_q.wp] = in_data;
      f_d.wp = f_q.wp + 1'b1;
    end
    if (pop) begin
      f_d.rp = f_q.rp + 1'b1;
    end
    f_d.cnt = f_q.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end
endmodule

module srr_rings #(
  parameter int QD = 4,
  parameter logic [7:0] RX_STS_NUM = 8'h10,
  parameter logic [7:0] OVF_STS_NUM = 8'h20
) (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic [23:0] CMD_RING_BASE,
  input wire logic [2:0] COMMAND_SLOT_COUNT_LOG2,
  input wire logic [2:0] STATUS_SLOT_COUNT_LOG2,
  input wire logic [2:0] RX_SLOT_COUNT_LOG2,
  input wire logic LINE_OPEN,
  input wire logic RX_CHAIN_MODE,
  input wire logic RX_ADDR_HIGH_FIRST,
  input wire logic [14:0] RX_BUF_SIZE,
  input wire logic TX_CMD_VALID,
  input wire logic [23:0] TX_CMD_START,
  input wire logic [14:0] TX_CMD_SIZE,
  output logic [23:0] TX_BUF_START,
  output logic [14:0] TX_BUF_SIZE,
  input wire logic STS_VALID,
  output logic STS_READY,
  input wire logic [7:0] STS_NUM,
  input wire logic [3:0] STS_LEN,
  input wire logic [119:0] STS_INFO,
  output logic STS_OVERFLOW,
  input wire logic RX_VALID,
  output logic RX_READY,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_FRAME_END,
  input wire logic RX_FCS_OK,
  output logic [7:0] RX_QUEUE_LEVEL,
  output logic BUS_HOLD_REQUEST,
  input wire logic BUS_HOLD_GRANT,
  output logic [23:0] MEM_ADDR,
  output logic [7:0] MEM_WDATA,
  output logic MEM_RD,
  output logic MEM_WR,
  input wire logic [7:0] MEM_RDATA,
  input wire logic MEM_ACK,
  output logic HOST_IRQ,
  input wire logic IRQ_CLEAR_INPUT
);
  localparam int QW = $clog2(QD);

  typedef struct packed {
    srr_pkg::srr_state_t st;
    logic [23:0] addr;
    logic [7:0] wdata;
    logic rd;
    logic wr;
    logic [6:0] sts_ptr;
    logic [6:0] rxa_ptr;
    logic pend;
    logic [7:0] pnum;
    logic [3:0] plen;
    logic [119:0] pinfo;
    logic ovf;
    logic irq;
    logic [3:0] idx;
    logic [23:0] fetch;
    logic [QD-1:0][23:0] qa;
    logic [QD-1:0][6:0] qs;
    logic [QW:0] qcnt;
    logic [QW-1:0] qrd;
    logic [QW-1:0] qwr;
    logic open;
    logic fend;
    logic fok;
    logic [14:0] rcnt;
    logic chd;
    logic [6:0] done_slot;
    logic [23:0] txs;
    logic [14:0] txn;
  } srr_regs_t;

  srr_regs_t r, n;
  logic [23:0] sts_base, rx_base, sts_ent, rxa_ent;
  logic [14:0] rx_lim;
  logic f_ov, f_pop;
  logic [7:0] f_od;

  // ------------------------------------------------------------
  // Ring placement
  // ------------------------------------------------------------
  // Both rings hang off the command ring, so a new command ring size
  // moves them; the host must not change sizes while the line is open.
  assign sts_base = CMD_RING_BASE +
    srr_pkg::ring_span(COMMAND_SLOT_COUNT_LOG2, srr_pkg::CMD_SHIFT);
  assign rx_base = sts_base +
    srr_pkg::ring_span(STATUS_SLOT_COUNT_LOG2, srr_pkg::STS_SHIFT);
  assign sts_ent = srr_pkg::ring_addr(sts_base, r.sts_ptr,
    STATUS_SLOT_COUNT_LOG2, srr_pkg::STS_SHIFT);
  assign rxa_ent = srr_pkg::ring_addr(rx_base, r.rxa_ptr,
    RX_SLOT_COUNT_LOG2, srr_pkg::RXA_SHIFT);
  assign rx_lim = (RX_BUF_SIZE > srr_pkg::BUF_MAX) ? srr_pkg::BUF_MAX
                                                   : RX_BUF_SIZE;

  // ------------------------------------------------------------
  // Receive data buffer
  // ------------------------------------------------------------
  // New data is held off while a frame end waits, so frames never mix.
  logic f_ir;
  srr_fifo #(.W(8), .D(16)) u_rxf (
    .clk(CORE_CLK),
    .rst(RESET),
    .in_valid(RX_VALID && !r.fend),
    .in_ready(f_ir),
    .in_data(RX_DATA),
    .out_valid(f_ov),
    .out_ready(f_pop),
    .out_data(f_od)
  );

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_comb begin
    n = r;
    f_pop = 1'b0;
    n.open = LINE_OPEN;
    if (STS_VALID && r.pend) begin
      n.ovf = 1'b1;
    end
    if (STS_VALID && !r.pend) begin
      n.pend = 1'b1;
      n.pnum = STS_NUM;
      n.plen = STS_LEN;
      n.pinfo = STS_INFO;
    end
    if (IRQ_CLEAR_INPUT) begin
      n.irq = 1'b0;
    end
    if (TX_CMD_VALID) begin
      n.txs = TX_CMD_START;
      n.txn = (TX_CMD_SIZE > srr_pkg::BUF_MAX) ? srr_pkg::BUF_MAX : TX_CMD_SIZE;
    end
    unique case (r.st)
      srr_pkg::S_IDLE: begin
        if (r.chd) begin
          n.st = srr_pkg::S_CHD;
          n.addr = srr_pkg::ring_addr(rx_base, r.done_slot,
            RX_SLOT_COUNT_LOG2, srr_pkg::RXA_SHIFT);
          n.wdata = srr_pkg::SLOT_FREE;
          n.wr = 1'b1;
        end else if (r.pend) begin
          n.st = srr_pkg::S_STS_CHK;
          n.addr = sts_ent;
          n.rd = 1'b1;
        end else if (r.ovf && !STS_VALID) begin
          n.ovf = 1'b0;
          n.pend = 1'b1;
          n.pnum = OVF_STS_NUM;
          n.plen = 4'h0;
        end else if (r.fend && !f_ov && !STS_VALID) begin
          n.fend = 1'b0;
          n.rcnt = 15'h0000;
          // A bad frame leaves the head slot in place for the next one
          if (r.fok) begin
            n.pend = 1'b1;
            n.pnum = RX_STS_NUM;
            n.plen = srr_pkg::RX_STS_LEN;
            n.pinfo = {105'h0, r.rcnt};
            if (r.qcnt != '0) begin
              n.qrd = r.qrd + 1'b1;
              n.qcnt = r.qcnt - 1'b1;
              n.chd = RX_CHAIN_MODE;
              n.done_slot = r.qs[r.qrd];
            end
          end
        end else if (f_ov && r.qcnt != '0) begin
          // Bytes past the buffer end are dropped rather than stalling the line
          if (r.rcnt >= rx_lim) begin
            f_pop = 1'b1;
          end else begin
            n.st = srr_pkg::S_RXD;
            n.addr = r.qa[r.qrd] + 24'(r.rcnt);
            n.wdata = f_od;
            n.wr = 1'b1;
          end
        end else if (r.open && r.qcnt < (QW+1)'(QD)) begin
          n.st = srr_pkg::S_RXA_CHK;
          n.addr = rxa_ent;
          n.rd = 1'b1;
        end
      end
      srr_pkg::S_STS_CHK: begin
        if (MEM_ACK) begin
          n.rd = 1'b0;
          if (MEM_RDATA != srr_pkg::SLOT_FREE) begin
            n.st = srr_pkg::S_IDLE;
          end else if (r.plen == 4'h0) begin
            n.st = srr_pkg::S_STS_NUM;
            n.wdata = r.pnum;
            n.wr = 1'b1;
          end else begin
            n.st = srr_pkg::S_STS_DET;
            n.idx = 4'h1;
            n.addr = sts_ent + 24'h000001;
            n.wdata = r.pinfo[7:0];
            n.pinfo = r.pinfo >> 8;
            n.wr = 1'b1;
          end
        end
      end
      srr_pkg::S_STS_DET: begin
        if (MEM_ACK) begin
          if (r.idx == r.plen) begin
            n.st = srr_pkg::S_STS_NUM;
            n.addr = sts_ent;
            n.wdata = r.pnum;
          end else begin
            n.idx = r.idx + 4'h1;
            n.addr = sts_ent + 24'(r.idx) + 24'h000001;
            n.wdata = r.pinfo[7:0];
            n.pinfo = r.pinfo >> 8;
          end
        end
      end
      srr_pkg::S_STS_NUM: begin
        if (MEM_ACK) begin
          n.wr = 1'b0;
          n.st = srr_pkg::S_IDLE;
          n.pend = 1'b0;
          n.irq = 1'b1;
          n.sts_ptr = srr_pkg::ring_next(r.sts_ptr, STATUS_SLOT_COUNT_LOG2);
        end
      end
      srr_pkg::S_RXA_CHK: begin
        if (MEM_ACK) begin
          if (MEM_RDATA == srr_pkg::SLOT_READY) begin
            n.st = srr_pkg::S_RXA_ADR;
            n.idx = 4'h1;
            n.addr = rxa_ent + 24'h000001;
          end else begin
            n.rd = 1'b0;
            n.st = srr_pkg::S_IDLE;
          end
        end
      end
      srr_pkg::S_RXA_ADR: begin
        if (MEM_ACK) begin
          n.fetch = RX_ADDR_HIGH_FIRST ? {r.fetch[15:0], MEM_RDATA}
                                       : {MEM_RDATA, r.fetch[23:8]};
          if (r.idx == 4'(srr_pkg::ADDR_BYTES)) begin
            n.st = srr_pkg::S_RXA_MRK;
            n.rd = 1'b0;
            n.wr = 1'b1;
            n.addr = rxa_ent;
            n.wdata = RX_CHAIN_MODE ? srr_pkg::SLOT_CHAIN
                                    : srr_pkg::SLOT_FREE;
          end else begin
            n.idx = r.idx + 4'h1;
            n.addr = rxa_ent + 24'(r.idx) + 24'h000001;
          end
        end
      end
      srr_pkg::S_RXA_MRK: begin
        if (MEM_ACK) begin
          n.wr = 1'b0;
          n.st = srr_pkg::S_IDLE;
          n.qa[r.qwr] = r.fetch;
          n.qs[r.qwr] = r.rxa_ptr;
          n.qwr = r.qwr + 1'b1;
          n.qcnt = r.qcnt + 1'b1;
          n.rxa_ptr = srr_pkg::ring_next(r.rxa_ptr, RX_SLOT_COUNT_LOG2);
        end
      end
      srr_pkg::S_RXD: begin
        if (MEM_ACK) begin
          n.wr = 1'b0;
          n.st = srr_pkg::S_IDLE;
          f_pop = 1'b1;
          n.rcnt = r.rcnt + 15'h0001;
        end
      end
      srr_pkg::S_CHD: begin
        if (MEM_ACK) begin
          n.wr = 1'b0;
          n.chd = 1'b0;
          n.st = srr_pkg::S_IDLE;
        end
      end
      default: begin
        n.st = srr_pkg::S_IDLE;
        n.rd = 1'b0;
        n.wr = 1'b0;
      end
    endcase
    if (RX_FRAME_END) begin
      n.fend = 1'b1;
      n.fok = RX_FCS_OK;
    end
    // Opening the line restarts the slot walk; a fetch in flight still completes and is queued, unless its mark is acknowledged in the opening cycle
    if (LINE_OPEN && !r.open) begin
      n.rxa_ptr = 7'h00;
      n.qcnt = '0;
      n.qrd = '0;
      n.qwr = '0;
      n.rcnt = 15'h0000;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign BUS_HOLD_REQUEST = r.st != srr_pkg::S_IDLE;
  assign MEM_RD = r.rd && BUS_HOLD_GRANT;
  assign MEM_WR = r.wr && BUS_HOLD_GRANT;
  assign MEM_ADDR = r.addr;
  assign MEM_WDATA = r.wdata;
  assign HOST_IRQ = r.irq;
  assign STS_READY = !r.pend;
  assign STS_OVERFLOW = r.ovf;
  assign RX_READY = f_ir && !r.fend;
  assign RX_QUEUE_LEVEL = 8'(r.qcnt);
  assign TX_BUF_START = r.txs;
  assign TX_BUF_SIZE = r.txn;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  strobe_needs_grant_a: assert property ((MEM_RD || MEM_WR) |->
    BUS_HOLD_GRANT && BUS_HOLD_REQUEST) else $error("strobe without grant");
  detail_before_num_a: assert property ((r.st == srr_pkg::S_STS_DET && MEM_WR) |->
    MEM_ADDR != sts_ent) else $error("number byte written early");
  irq_after_post_a: assert property ((r.st == srr_pkg::S_STS_NUM && MEM_ACK) |=>
    HOST_IRQ && STS_READY) else $error("no irq after post");
  irq_clear_a: assert property ((IRQ_CLEAR_INPUT &&
    !(r.st == srr_pkg::S_STS_NUM && MEM_ACK)) |=> !HOST_IRQ)
    else $error("irq not cleared");
  sts_wrap_a: assert property ((r.st == srr_pkg::S_STS_NUM && MEM_ACK &&
    r.sts_ptr == srr_pkg::ring_mask(STATUS_SLOT_COUNT_LOG2)) |=> r.sts_ptr == 7'h00)
    else $error("status pointer did not wrap");
  busy_retry_a: assert property ((r.st == srr_pkg::S_STS_CHK && MEM_ACK &&
    MEM_RDATA != srr_pkg::SLOT_FREE) |=> r.st == srr_pkg::S_IDLE && !STS_READY
    ##1 r.st == srr_pkg::S_STS_CHK) else $error("busy entry not retried");
  lost_status_a: assert property ((STS_VALID && !STS_READY) |=> STS_OVERFLOW)
    else $error("overflow not raised");
  slot_mark_a: assert property ((r.st == srr_pkg::S_RXA_MRK && MEM_WR) |->
    MEM_WDATA == (RX_CHAIN_MODE ? srr_pkg::SLOT_CHAIN : srr_pkg::SLOT_FREE))
    else $error("wrong slot mark");
  slot_wait_a: assert property ((r.st == srr_pkg::S_RXA_CHK && MEM_ACK &&
    MEM_RDATA != srr_pkg::SLOT_READY && !(LINE_OPEN && !r.open)) |=>
    r.rxa_ptr == $past(r.rxa_ptr)) else $error("unready slot skipped");
  bad_frame_a: assert property ((r.st == srr_pkg::S_IDLE && r.fend && !r.fok &&
    !f_ov && !r.chd && !r.pend && !r.ovf && !STS_VALID) |=>
    STS_READY && RX_QUEUE_LEVEL == $past(RX_QUEUE_LEVEL))
    else $error("bad frame consumed slot");

endmodule

`default_nettype wire

// file: tb/srr_host_mem.sv
/*
  Behavioural host and shared byte memory facing the ring DMA block.
  Assumes one clock; grants the bus and answers strobes just after an edge.
*/
`default_nettype none

module srr_host_mem (
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic req,
  input wire logic rd,
  input wire logic wr,
  input wire logic [23:0] addr,
  input wire logic [7:0] wdata,
  output logic grant,
  output logic ack,
  output logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [logic [23:0]];
  logic [23:0] wlog [$];
  int g;
  int w;

  // Unwritten bytes read FFH: the host clears memory to FFH before use
  function automatic logic [7:0] peek(input logic [23:0] a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction

  initial begin
    grant = 1'b0;
    ack = 1'b0;
    rdata = 8'h00;
    g = 0;
    w = 0;
  end

  // ------------------------------------------------------------
  // Grant and answer
  // ------------------------------------------------------------
  always @(posedge clk) begin
    #1;
    g = (req && !rst) ? g + 1 : 0;
    grant <= g > (slow ? 3 : 0);
    if (ack) begin
      ack <= 1'b0;
      rdata <= ~rdata;  // Released data lines do not keep the last value
    end else if ((rd || wr) && w < (slow ? 2 : 0)) begin
      w++;
    end else if (rd || wr) begin
      w = 0;
      ack <= 1'b1;
      if (rd) begin
        rdata <= peek(addr);
      end else begin
        mem[addr] = wdata;
        wlog.push_back(addr);
      end
    end
  end
endmodule

`default_nettype wire

// file: tb/tb.sv
/*
  Self-checking bench for the status ring and receive-address ring DMA.
  Assumes the host memory model answers the bus; rings sit at 1000H.
*/
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [23:0] SB = 24'h001020;
  localparam logic [23:0] RB = 24'h001040;
  localparam logic [7:0] RXS = 8'h10;
  localparam logic [7:0] OVS = 8'h20;
  logic CORE_CLK, RESET, LINE_OPEN, RX_CHAIN_MODE, RX_ADDR_HIGH_FIRST, TX_CMD_VALID;
  logic [23:0] TX_CMD_START, TX_BUF_START, MEM_ADDR, CMD_RING_BASE;
  logic [14:0] TX_CMD_SIZE, TX_BUF_SIZE, RX_BUF_SIZE;
  logic STS_VALID, STS_READY, STS_OVERFLOW, RX_VALID, RX_READY, RX_FRAME_END, RX_FCS_OK;
  logic [7:0] STS_NUM, RX_DATA, RX_QUEUE_LEVEL, MEM_WDATA, MEM_RDATA;
  logic [3:0] STS_LEN;
  logic [119:0] STS_INFO;
  logic BUS_HOLD_REQUEST, BUS_HOLD_GRANT, MEM_RD, MEM_WR, MEM_ACK, HOST_IRQ;
  logic IRQ_CLEAR_INPUT, slow;
  int fails = 0;
  int checks_done = 0;

  srr_rings #(.QD(4), .RX_STS_NUM(RXS), .OVF_STS_NUM(OVS)) dut_u (
    .CORE_CLK(CORE_CLK), .RESET(RESET), .CMD_RING_BASE(CMD_RING_BASE),
    .COMMAND_SLOT_COUNT_LOG2(3'h1), .STATUS_SLOT_COUNT_LOG2(3'h1),
    .RX_SLOT_COUNT_LOG2(3'h1), .LINE_OPEN(LINE_OPEN), .RX_CHAIN_MODE(RX_CHAIN_MODE),
    .RX_ADDR_HIGH_FIRST(RX_ADDR_HIGH_FIRST), .RX_BUF_SIZE(RX_BUF_SIZE),
    .TX_CMD_VALID(TX_CMD_VALID), .TX_CMD_START(TX_CMD_START), .TX_CMD_SIZE(TX_CMD_SIZE),
    .TX_BUF_START(TX_BUF_START), .TX_BUF_SIZE(TX_BUF_SIZE), .STS_VALID(STS_VALID),
    .STS_READY(STS_READY), .STS_NUM(STS_NUM), .STS_LEN(STS_LEN), .STS_INFO(STS_INFO),
    .STS_OVERFLOW(STS_OVERFLOW), .RX_VALID(RX_VALID), .RX_READY(RX_READY),
    .RX_DATA(RX_DATA), .RX_FRAME_END(RX_FRAME_END), .RX_FCS_OK(RX_FCS_OK),
    .RX_QUEUE_LEVEL(RX_QUEUE_LEVEL), .BUS_HOLD_REQUEST(BUS_HOLD_REQUEST),
    .BUS_HOLD_GRANT(BUS_HOLD_GRANT), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
    .MEM_RD(MEM_RD), .MEM_WR(MEM_WR), .MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK),
    .HOST_IRQ(HOST_IRQ), .IRQ_CLEAR_INPUT(IRQ_CLEAR_INPUT)
  );

  srr_host_mem hm (
    .clk(CORE_CLK), .rst(RESET), .slow(slow), .req(BUS_HOLD_REQUEST), .rd(MEM_RD),
    .wr(MEM_WR), .addr(MEM_ADDR), .wdata(MEM_WDATA), .grant(BUS_HOLD_GRANT),
    .ack(MEM_ACK), .rdata(MEM_RDATA)
  );

  always #5 CORE_CLK = ~CORE_CLK;

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic finish_test;
    $display("Checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge CORE_CLK);
    #1;
  endtask

  // Bounded wait; the check that follows reports a miss
  task automatic wmem(input logic [23:0] a, input logic [7:0] v);
    int i;
    i = 0;
    while (hm.peek(a) !== v && i < 3000) begin
      tick(1);
      i++;
    end
  endtask

  task automatic wirq;
    int i;
    i = 0;
    while (HOST_IRQ !== 1'b1 && i < 3000) begin
      tick(1);
      i++;
    end
    chk("irq raised", 1, HOST_IRQ);
  endtask

  // Let a post already acknowledged set its flag first; set wins over clear
  task automatic clr_irq;
    tick(2);
    IRQ_CLEAR_INPUT = 1'b1;
    tick(1);
    IRQ_CLEAR_INPUT = 1'b0;
    tick(1);
    chk("irq cleared", 0, HOST_IRQ);
  endtask

  task automatic free_sts;
    hm.mem[SB] = 8'hFF;
    hm.mem[SB + 24'h000010] = 8'hFF;
  endtask

  // Offering a status while not ready counts as a lost one, so wait first
  task automatic post(input logic [7:0] n, input logic [3:0] l, input logic [119:0] d);
    int i;
    i = 0;
    while (STS_READY !== 1'b1 && i < 3000) begin
      tick(1);
      i++;
    end
    STS_NUM = n;
    STS_LEN = l;
    STS_INFO = d;
    STS_VALID = 1'b1;
    tick(1);
    STS_VALID = 1'b0;
    tick(1);
  endtask

  // Address bytes first, state byte last
  task automatic fill(input int s, input logic [23:0] a);
    logic [23:0] p;
    p = RB + 24'(4 * s);
    hm.mem[p + 24'h000001] = RX_ADDR_HIGH_FIRST ? a[23:16] : a[7:0];
    hm.mem[p + 24'h000002] = a[15:8];
    hm.mem[p + 24'h000003] = RX_ADDR_HIGH_FIRST ? a[7:0] : a[23:16];
    hm.mem[p] = 8'h00;
  endtask

  task automatic frame(input logic [15:0] d, input int n, input logic ok);
    int i;
    for (int k = 0; k < n; k++) begin
      i = 0;
      RX_DATA = d[8*k +: 8];
      RX_VALID = 1'b1;
      while (RX_READY !== 1'b1 && i < 3000) begin
        tick(1);
        i++;
      end
      tick(1);
    end
    RX_VALID = 1'b0;
    RX_FRAME_END = 1'b1;
    RX_FCS_OK = ok;
    tick(1);
    RX_FRAME_END = 1'b0;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_tx;
    TX_CMD_START = 24'hABCDEF;
    TX_CMD_SIZE = 15'h7FFF;
    TX_CMD_VALID = 1'b1;
    tick(1);
    TX_CMD_VALID = 1'b0;
    tick(1);
    chk("tx start", 24'hABCDEF, TX_BUF_START);
    chk("tx size clamp", 24'h004000, TX_BUF_SIZE);
  endtask

  task automatic t_status;
    chk("hold idle", 0, BUS_HOLD_REQUEST);
    post(8'h41, 4'h2, 120'hB2B1);
    wirq;
    chk("sts number", 8'h41, hm.peek(SB));
    chk("sts detail1", 8'hB1, hm.peek(SB + 24'h000001));
    chk("sts detail2", 8'hB2, hm.peek(SB + 24'h000002));
    chk("number last", SB, hm.wlog[$]);
    clr_irq;
  endtask

  // Slow host: full ring, held status, lost status, wrap
  task automatic t_full;
    slow = 1'b1;
    post(8'h42, 4'h0, 120'h0);
    wmem(SB + 24'h000010, 8'h42);
    chk("entry one", 8'h42, hm.peek(SB + 24'h000010));
    post(8'h43, 4'h1, 120'hC1);
    tick(60);
    chk("busy entry kept", 8'h41, hm.peek(SB));
    chk("status held", 0, STS_READY);
    STS_NUM = 8'h44;
    STS_VALID = 1'b1;
    tick(1);
    STS_VALID = 1'b0;
    tick(2);
    chk("overflow flag", 1, STS_OVERFLOW);
    free_sts;
    wmem(SB, 8'h43);
    chk("wrap number", 8'h43, hm.peek(SB));
    chk("wrap detail", 8'hC1, hm.peek(SB + 24'h000001));
    wmem(SB + 24'h000010, OVS);
    chk("overflow report", OVS, hm.peek(SB + 24'h000010));
    clr_irq;
    free_sts;
    slow = 1'b0;
  endtask

  task automatic t_fetch;
    fill(0, 24'h002000);
    fill(1, 24'h003000);
    LINE_OPEN = 1'b1;
    wmem(RB + 24'h000004, 8'hFF);
    tick(80);
    chk("queue level", 2, RX_QUEUE_LEVEL);
    chk("slot0 mark", 8'hFF, hm.peek(RB));
    chk("slot1 mark", 8'hFF, hm.peek(RB + 24'h000004));
  endtask

  task automatic t_frames;
    frame(16'h3130, 2, 1'b1);
    wirq;
    chk("data0", 8'h30, hm.peek(24'h002000));
    chk("data1", 8'h31, hm.peek(24'h002001));
    chk("rx status", RXS, hm.peek(SB));
    chk("rx count lo", 8'h02, hm.peek(SB + 24'h000001));
    chk("rx count hi", 8'h00, hm.peek(SB + 24'h000002));
    chk("level popped", 1, RX_QUEUE_LEVEL);
    clr_irq;
    free_sts;
    fill(0, 24'h002000);
    wmem(RB, 8'hFF);
    tick(20);
    chk("refetch wrap", 2, RX_QUEUE_LEVEL);
    frame(16'h0040, 1, 1'b0);
    tick(40);
    chk("bad frame silent", 0, HOST_IRQ);
    frame(16'h0050, 1, 1'b1);
    wirq;
    chk("slot reused", 8'h50, hm.peek(24'h003000));
    chk("reuse count", 8'h01, hm.peek(SB + 24'h000011));
    clr_irq;
    free_sts;
  endtask

  task automatic t_chain;
    LINE_OPEN = 1'b0;
    RX_CHAIN_MODE = 1'b1;
    RX_ADDR_HIGH_FIRST = 1'b0;
    RX_BUF_SIZE = 15'h0001;
    tick(2);
    fill(0, 24'h004010);
    LINE_OPEN = 1'b1;
    wmem(RB, 8'hF0);
    chk("chain mark", 8'hF0, hm.peek(RB));
    frame(16'h6160, 2, 1'b1);
    wirq;
    wmem(RB, 8'hFF);
    chk("chain done", 8'hFF, hm.peek(RB));
    chk("low first addr", 8'h60, hm.peek(24'h004010));
    chk("buffer limit", 8'hFF, hm.peek(24'h004011));
    chk("limit count", 8'h01, hm.peek(SB + 24'h000001));
    RX_BUF_SIZE = 15'h4000;
    clr_irq;
  endtask

  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    CORE_CLK = 1'b0;
    RESET = 1'b1;
    {LINE_OPEN, RX_CHAIN_MODE, TX_CMD_VALID, STS_VALID, RX_VALID} = 5'h00;
    {RX_FRAME_END, RX_FCS_OK, IRQ_CLEAR_INPUT, slow} = 4'h0;
    RX_ADDR_HIGH_FIRST = 1'b1;
    CMD_RING_BASE = 24'h001000;
    RX_BUF_SIZE = 15'h4000;
    TX_CMD_START = 24'h000000;
    TX_CMD_SIZE = 15'h0000;
    STS_NUM = 8'h00;
    STS_LEN = 4'h0;
    STS_INFO = 120'h0;
    RX_DATA = 8'h00;
    tick(8);
    RESET = 1'b0;
    tick(1);
    t_tx;
    t_status;
    t_full;
    t_fetch;
    t_frames;
    t_chain;
    finish_test;
  end

  // Whole run needs well under 20000 cycles
  initial begin
    #500000;
    fails++;
    finish_test;
  end
endmodule

`default_nettype wire
